/* core/mpp_pkg.sv */
// Constants and types shared by the meter setting and post-processing block.
// Assumes a single 10 MHz clock; all slower timing comes from a tick enable.
package mpp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Timing.
    localparam int CLK_NS = 100;
    localparam int TICK_MS = 100;
    localparam int TICK_CYC = TICK_MS * 1000000 / CLK_NS;
    localparam int HOLD_ENTER_MS = 3000;
    localparam int HOLD_BACK_MS = 1000;
    localparam logic [5:0] HOLD_ENTER_TK = 6'(HOLD_ENTER_MS / TICK_MS);
    localparam logic [5:0] HOLD_BACK_TK = 6'(HOLD_BACK_MS / TICK_MS);

    ////////////////////////////////////////////////////////////////////////
    // Setting ranges, in tenths of a second, display digits or colour mode codes.
    localparam logic [7:0] TMO_MAX = 8'hc7;
    localparam logic [9:0] STUP_MAX = 10'h3e7;
    localparam logic [6:0] LIM_MAX = 7'h63;
    localparam logic [1:0] COLOR_MAX = 2'h3;
    localparam logic signed [15:0] MOVE_MIN = 16'shf831;
    localparam logic signed [15:0] MOVE_MAX = 16'sh270f;
    localparam logic signed [15:0] ADMIT_CODE = 16'shff57;

    ////////////////////////////////////////////////////////////////////////
    // Values after reset.
    localparam logic [7:0] TMO_RST = 8'h32;
    localparam logic [9:0] STUP_RST = 10'h000;
    localparam logic LIM_EN_RST = 1'b0;
    localparam logic [6:0] LIM_RST = 7'h00;
    localparam logic [1:0] COLOR_RST = 2'h2;

    ////////////////////////////////////////////////////////////////////////
    // Colour modes, level indicator codes and key bit positions.
    localparam logic [1:0] COL_GREEN = 2'h0;
    localparam logic [1:0] COL_RED = 2'h1;
    localparam logic [1:0] COL_G2R = 2'h2;
    localparam logic [1:0] COL_R2G = 2'h3;
    localparam logic [3:0] IND_OP = 4'h0;
    localparam logic [3:0] IND_INIT = 4'h5;
    localparam logic [3:0] IND_ADV = 4'hf;
    localparam int K_LVL = 0;
    localparam int K_MODE = 1;
    localparam int K_SHIFT = 2;
    localparam int K_UP = 3;

    ////////////////////////////////////////////////////////////////////////
    // Parameter selection codes.
    localparam logic [2:0] P_MOVE = 3'h0;
    localparam logic [2:0] P_TMO = 3'h1;
    localparam logic [2:0] P_STUP = 3'h2;
    localparam logic [2:0] P_CLEN = 3'h3;
    localparam logic [2:0] P_LIM = 3'h4;
    localparam logic [2:0] P_COLOR = 3'h5;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets.
    localparam logic [7:0] A_TMO = 8'h00;
    localparam logic [7:0] A_STUP = 8'h04;
    localparam logic [7:0] A_CLAMP = 8'h08;
    localparam logic [7:0] A_COLOR = 8'h0c;
    localparam logic [7:0] A_STAT = 8'h10;

    typedef enum logic [1:0] {LV_OP, LV_INIT, LV_ADV} mpp_lv_t;
    typedef enum logic [1:0] {VW_NAME, VW_SHOW, VW_EDIT} mpp_vw_t;

endpackage

/* core/mpp_sync.sv */
// Three-stage pin synchroniser; a change counts once stages two and three
// agree. Assumes the inputs are asynchronous to mclk.
`timescale 1ns/1ps
module mpp_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Pins in, clean levels out.
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } mpp_sync_st_t;

    mpp_sync_st_t st_r;
    mpp_sync_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.q = (st_r.s2 & st_r.s3) | (st_r.q & (st_r.s2 ^ st_r.s3));
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.q;

endmodule

/* core/mpp_tick.sv */
// Divider giving a one-cycle enable every CYC clocks.
// Assumes CYC is at least two.
`timescale 1ns/1ps
module mpp_tick #(
    parameter int CYC = 2
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Enable pulse.
    output logic tick
);

    localparam int CW = $clog2(CYC);

    typedef struct packed {
        logic [CW-1:0] cnt;
        logic tk;
    } mpp_tick_st_t;

    mpp_tick_st_t st_r;
    mpp_tick_st_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tk = 1'b0;
        if (st_r.cnt == CW'(CYC - 1))
        begin
            st_nxt.cnt = '0;
            st_nxt.tk = 1'b1;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tk;

endmodule

/* core/mpp_top.sv */
// Meter setting levels, auto-zero, start-up delay, zero clamp and colour.
// Assumes key and pulse pins are asynchronous; process value, comparative
// output and the register port are synchronous to mclk.
//
// How it works
// R1 - Auto-zero time held in tenths of a second, 0.0 to 19.9.
// R2 - No pulse for the auto-zero time forces the readout to zero.
// R3 - User must set auto-zero longer than the longest pulse interval.
// R4 - Start-up delay held in tenths of a second, 0.0 to 99.9.
// R5 - After reset nothing is shown until the start-up delay ends.
// R6 - Zero clamp can be switched off; then values pass unclamped.
// R7 - Zero clamp threshold is settable from 0 to 99 digits.
// R8 - With clamp on, values below the threshold display as zero.
// R9 - Four colour modes; switching modes follow the comparative output.
// R10 - Level key held three seconds at operation enters level 5.
// R11 - Code -0169 committed in the move parameter enters level F.
// R12 - Second shift press enters the blinking change state.
// R13 - Mode key commits the edited value, then shows the next parameter; the code stores no move value and stays on move unless -0169 is committed.
// R14 - Level key held one second steps back one level.
// R15 - Each rising pulse edge restarts the auto-zero timer; readout resumes.
`timescale 1ns/1ps
module mpp_top
    import mpp_pkg::*;
#(
    parameter int TICK_CYC = mpp_pkg::TICK_CYC
) (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Front-panel key pins: level, mode, shift, up.
    input wire logic [3:0] key_pin,
    // Pulse input pin.
    input wire logic pulse_pin,
    // Measurement side.
    input wire logic signed [15:0] proc_value,
    input wire logic cmp_on,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Display side.
    output logic signed [15:0] disp_value,
    output logic disp_valid,
    output logic readout_zero,
    output logic color_red,
    output logic color_green,
    output logic [3:0] level_ind,
    output logic [2:0] param_sel,
    output logic show_value,
    output logic blink,
    output logic signed [15:0] edit_value
);
    import mpp_pkg::*;

    typedef struct packed {
        mpp_lv_t level;
        mpp_vw_t view;
        logic [2:0] param;
        logic signed [15:0] edit;
        logic [7:0] pulse_timeout_time;
        logic [9:0] startup_delay_time;
        logic clamp_enable;
        logic [6:0] lim;
        logic [1:0] color;
        logic [3:0] key_prev;
        logic [5:0] lvl_cnt;
        logic lvl_done;
        logic [7:0] az_cnt;
        logic az;
        logic pls_prev;
        logic [9:0] st_cnt;
        logic run;
        logic signed [15:0] disp;
        logic red;
        logic green;
        logic [3:0] ind;
        logic shw;
        logic blk;
        logic [31:0] rdata;
    } mpp_main_st_t;

    mpp_main_st_t st_r;
    mpp_main_st_t st_nxt;
    logic [4:0] pins_s;
    logic [3:0] keys_s;
    logic pulse_s;
    logic tick;
    logic [3:0] kp;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchroniser and tenth-second tick.
    mpp_sync #(.WIDTH(5)) u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .din({pulse_pin, key_pin}),
        .dout(pins_s)
    );

    mpp_tick #(.CYC(TICK_CYC)) u_tick (
        .mclk(mclk),
        .rstn(rstn),
        .tick(tick)
    );

    assign keys_s = pins_s[3:0];
    assign pulse_s = pins_s[4];
    assign kp = keys_s & ~st_r.key_prev;

    ////////////////////////////////////////////////////////////////////////
    // Parameter range and value decoding.
    function automatic logic signed [15:0] pmin(input logic [2:0] p);
        pmin = (p == P_MOVE) ? MOVE_MIN : 16'sh0000;
    endfunction

    function automatic logic signed [15:0] pmax(input logic [2:0] p);
        case (p)
            P_MOVE: pmax = MOVE_MAX;
            P_TMO: pmax = {8'h00, TMO_MAX};
            P_STUP: pmax = {6'h00, STUP_MAX};
            P_CLEN: pmax = 16'sh0001;
            P_LIM: pmax = {9'h000, LIM_MAX};
            default: pmax = {14'h0000, COLOR_MAX};
        endcase
    endfunction

    function automatic logic signed [15:0] pget(input mpp_main_st_t s);
        case (s.param)
            P_TMO: pget = {8'h00, s.pulse_timeout_time};
            P_STUP: pget = {6'h00, s.startup_delay_time};
            P_CLEN: pget = {15'h0000, s.clamp_enable};
            P_LIM: pget = {9'h000, s.lim};
            P_COLOR: pget = {14'h0000, s.color};
            default: pget = 16'sh0000;
        endcase
    endfunction

    function automatic logic [2:0] pnext(input logic [2:0] p,
                                         input logic en);
        case (p)
            P_TMO: pnext = P_STUP;
            P_STUP: pnext = P_CLEN;
            P_CLEN: pnext = en ? P_LIM : P_COLOR;
            P_LIM: pnext = P_COLOR;
            default: pnext = P_TMO;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.key_prev = keys_s;
        st_nxt.pls_prev = pulse_s;
        st_nxt.rdata = 32'h0000_0000;
        if (st_r.st_cnt >= st_r.startup_delay_time)
        begin
            st_nxt.run = 1'b1; // [R5]
        end
        else if (tick)
        begin
            st_nxt.st_cnt = st_r.st_cnt + 10'h001; // [R4]
        end
        if (pulse_s && !st_r.pls_prev)
        begin
            st_nxt.az_cnt = 8'h00; // [R15]
            st_nxt.az = 1'b0;
        end
        else
        begin
            if (tick && st_r.az_cnt != 8'hff)
            begin
                st_nxt.az_cnt = st_r.az_cnt + 8'h01;
            end
            st_nxt.az = st_r.az_cnt >= st_r.pulse_timeout_time; // [R1] [R2]
        end
        if (!st_r.run || st_r.az)
        begin
            st_nxt.disp = 16'sh0000; // [R2] [R5]
        end
        else if (st_r.clamp_enable &&
                 proc_value < $signed({9'h000, st_r.lim}))
        begin
            st_nxt.disp = 16'sh0000; // [R8]
        end
        else
        begin
            st_nxt.disp = proc_value; // [R6]
        end
        unique case (st_r.color)
            COL_GREEN: st_nxt.red = 1'b0; // [R9]
            COL_RED: st_nxt.red = 1'b1;
            COL_G2R: st_nxt.red = cmp_on;
            COL_R2G: st_nxt.red = !cmp_on;
        endcase
        if (!keys_s[K_LVL])
        begin
            st_nxt.lvl_cnt = 6'h00;
            st_nxt.lvl_done = 1'b0;
        end
        else if (tick && st_r.lvl_cnt != 6'h3f)
        begin
            st_nxt.lvl_cnt = st_r.lvl_cnt + 6'h01;
        end
        if (keys_s[K_LVL] && !st_r.lvl_done &&
            st_r.level == LV_OP && st_r.lvl_cnt >= HOLD_ENTER_TK)
        begin
            st_nxt.level = LV_INIT; // [R10]
            st_nxt.param = P_MOVE;
            st_nxt.view = VW_NAME;
            st_nxt.lvl_done = 1'b1;
        end
        else if (keys_s[K_LVL] && !st_r.lvl_done &&
                 st_r.level != LV_OP && st_r.lvl_cnt >= HOLD_BACK_TK)
        begin
            st_nxt.level = (st_r.level == LV_ADV) ? LV_INIT : LV_OP; // [R14]
            st_nxt.param = P_MOVE;
            st_nxt.view = VW_NAME;
            st_nxt.lvl_done = 1'b1;
        end
        else if (st_r.level != LV_OP && kp[K_SHIFT])
        begin
            unique case (st_r.view)
                VW_NAME:
                begin
                    st_nxt.view = VW_SHOW;
                    st_nxt.edit = pget(st_r);
                end
                VW_SHOW: st_nxt.view = VW_EDIT; // [R12]
                VW_EDIT: st_nxt.edit = (st_r.edit == pmin(st_r.param)) ?
                    pmax(st_r.param) : st_r.edit - 16'sh0001;
                default: st_nxt.view = VW_NAME;
            endcase
        end
        else if (st_r.level != LV_OP && kp[K_UP] && st_r.view == VW_EDIT)
        begin
            st_nxt.edit = (st_r.edit == pmax(st_r.param)) ?
                pmin(st_r.param) : st_r.edit + 16'sh0001;
        end
        else if (st_r.level != LV_OP && kp[K_MODE])
        begin
            st_nxt.view = VW_NAME;
            if (st_r.param == P_MOVE)
            begin
                if (st_r.view == VW_EDIT && st_r.edit == ADMIT_CODE)
                begin
                    st_nxt.level = LV_ADV; // [R11]
                    st_nxt.param = P_TMO;
                end
            end
            else
            begin
                if (st_r.view == VW_EDIT)
                begin
                    case (st_r.param) // [R13]
                        P_TMO: st_nxt.pulse_timeout_time = st_r.edit[7:0];
                        P_STUP: st_nxt.startup_delay_time = st_r.edit[9:0];
                        P_CLEN: st_nxt.clamp_enable = st_r.edit[0];
                        P_LIM: st_nxt.lim = st_r.edit[6:0]; // [R7]
                        default: st_nxt.color = st_r.edit[1:0];
                    endcase
                end
                st_nxt.param = pnext(st_r.param, st_nxt.clamp_enable);
            end
        end
        if (reg_wr)
        begin
            case (reg_addr)
                A_TMO: st_nxt.pulse_timeout_time = (reg_wdata[7:0] > TMO_MAX)
                    ? TMO_MAX : reg_wdata[7:0]; // [R1]
                A_STUP: st_nxt.startup_delay_time =
                    (reg_wdata[9:0] > STUP_MAX) ? STUP_MAX : reg_wdata[9:0];
                A_CLAMP:
                begin
                    st_nxt.clamp_enable = reg_wdata[0]; // [R6]
                    st_nxt.lim = (reg_wdata[14:8] > LIM_MAX) ? LIM_MAX :
                        reg_wdata[14:8]; // [R7]
                end
                A_COLOR: st_nxt.color = reg_wdata[1:0];
                default: st_nxt.color = st_r.color;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                A_TMO: st_nxt.rdata = {24'h000000, st_r.pulse_timeout_time};
                A_STUP: st_nxt.rdata = {22'h000000, st_r.startup_delay_time};
                A_CLAMP: st_nxt.rdata = {17'h00000, st_r.lim, 7'h00,
                                         st_r.clamp_enable};
                A_COLOR: st_nxt.rdata = {30'h00000000, st_r.color};
                A_STAT: st_nxt.rdata = {17'h00000, st_r.param, 2'h0,
                                        st_r.view, 2'h0, st_r.level, 2'h0,
                                        st_r.az, st_r.run};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        st_nxt.green = !st_nxt.red; // [R9]
        st_nxt.ind = (st_nxt.level == LV_INIT) ? IND_INIT :
            (st_nxt.level == LV_ADV) ? IND_ADV : IND_OP; // [R10] [R11]
        st_nxt.shw = st_nxt.view != VW_NAME;
        st_nxt.blk = st_nxt.view == VW_EDIT; // [R12]
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= '0;
            st_r.pulse_timeout_time <= TMO_RST;
            st_r.startup_delay_time <= STUP_RST;
            st_r.clamp_enable <= LIM_EN_RST;
            st_r.lim <= LIM_RST;
            st_r.color <= COLOR_RST;
            st_r.green <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign reg_rdata = st_r.rdata;
    assign disp_value = st_r.disp;
    assign disp_valid = st_r.run;
    assign readout_zero = st_r.az;
    assign color_red = st_r.red;
    assign color_green = st_r.green;
    assign level_ind = st_r.ind;
    assign param_sel = st_r.param;
    assign show_value = st_r.shw;
    assign blink = st_r.blk;
    assign edit_value = st_r.edit;

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    AST_TMO_RANGE: assert property (st_r.pulse_timeout_time <= 8'hc7) // [R1]
        else $error("auto-zero time out of range");
    AST_AZ_ZERO: assert property (st_r.az ##1 1'b1 |-> disp_value == 0) // [R2]
        else $error("readout not zero after pulse timeout");
    AST_STUP_WAIT: assert property (!disp_valid |-> ##1 disp_value == 0) // [R5]
        else $error("value shown during start-up delay");
    AST_NO_CLAMP: assert property (st_r.run && !st_r.az && // [R6]
        !st_r.clamp_enable |=> disp_value == $past(proc_value))
        else $error("value altered with clamp off");
    AST_CLAMP: assert property (st_r.run && st_r.clamp_enable && // [R8]
        proc_value < $signed({9'h000, st_r.lim}) |=> disp_value == 0)
        else $error("value below threshold not clamped");
    AST_COLOR: assert property (st_r.color == COL_R2G && cmp_on // [R9]
        |=> color_green)
        else $error("colour does not follow comparative output");
    AST_ENTER: assert property (level_ind == IND_OP ##1 // [R10]
        level_ind == IND_INIT |-> $past(st_r.lvl_cnt) >= 6'd30)
        else $error("level 5 entered without three second hold");
    AST_ADMIT: assert property (level_ind == IND_INIT ##1 // [R11]
        level_ind == IND_ADV |-> $past(st_r.edit) == -16'sd169)
        else $error("advanced level entered without code");
    AST_BLINK: assert property ($rose(blink) |-> $past(kp[K_SHIFT]) && // [R12]
        $past(show_value))
        else $error("change state entered without second shift");
    AST_COMMIT: assert property (blink && kp[K_MODE] && !kp[K_SHIFT] && // [R13]
        !kp[K_UP] && st_r.param == P_TMO && !keys_s[K_LVL] && !reg_wr
        |=> st_r.pulse_timeout_time == $past(st_r.edit[7:0]))
        else $error("edited value not committed");
    AST_BACK: assert property (level_ind == IND_ADV ##1 // [R14]
        level_ind == IND_INIT |-> $past(st_r.lvl_cnt) >= 6'd10)
        else $error("stepped back without one second hold");
    AST_PULSE: assert property (pulse_s && !st_r.pls_prev && // [R15]
        st_r.pulse_timeout_time != 8'h00 |=> st_r.az_cnt == 0 ##1 !st_r.az)
        else $error("pulse did not restart auto-zero timer");

endmodule

/* verif/mpp_panel_model.sv */
// Far-side model: front-panel keys and a pulse source.
// Assumes the bench asks for key levels and a pulse gap in clock cycles.
`timescale 1ns/1ps
module mpp_panel_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rstn,
    // Requests from the bench.
    input wire logic [3:0] key_req,
    input wire logic [31:0] pulse_gap,
    // Pins towards the meter.
    output logic [3:0] key_pin,
    output logic pulse_pin
);
    int cnt;

    ////////////////////////////////////////////////////////////////////////
    // Keys follow the requested levels, held as long as asked.
    assign key_pin = key_req;

    ////////////////////////////////////////////////////////////////////////
    // Pulses come more often than the auto-zero time, or stop when gap is 0.
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt <= 0;
            pulse_pin <= 1'b0;
        end
        else if (pulse_gap == 0)
        begin
            cnt <= 0;
            pulse_pin <= 1'b0;
        end
        else if (cnt >= pulse_gap - 1)
        begin
            cnt <= 0;
            pulse_pin <= ~pulse_pin;
        end
        else
        begin
            cnt <= cnt + 1;
        end
    end
endmodule

/* verif/meter_setting_postproc_bench.sv */
// Self-checking bench for the meter setting and post-processing block.
// Assumes a 10-cycle tick divider so all times scale down.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin \
    num_errors++; $display("[ERR] %s exp %0h got %0h", nm, ex, gt); end end
module meter_setting_postproc_bench;
    import mpp_pkg::*;
    typedef struct {bit w; logic [7:0] a; logic [31:0] d, e;} mpp_row_t;
    logic mclk, rstn, pulse_pin, cmp_on, reg_wr, reg_rd, disp_valid;
    logic readout_zero, color_red, color_green, show_value, blink;
    logic [3:0] key_pin, key_req, level_ind;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rv;
    logic signed [15:0] proc_value, disp_value, edit_value;
    logic [2:0] param_sel;
    int pulse_gap, num_errors, checks_done, cyc, n;
    logic exp_red;
    mpp_row_t rows[14] = '{
        '{0, A_TMO, 0, 32'h32}, '{0, A_STUP, 0, 0}, '{0, A_CLAMP, 0, 0},
        '{0, A_COLOR, 0, 32'h2}, '{0, A_STAT, 0, 32'h1},
        '{1, A_TMO, 32'h0a, 32'h0a},
        '{1, A_TMO, 32'hff, 32'hc7}, '{1, A_STUP, 32'h3e7, 32'h3e7},
        '{1, A_STUP, 32'h3ff, 32'h3e7}, '{1, A_CLAMP, 32'h6301, 32'h6301},
        '{1, A_CLAMP, 32'h7f01, 32'h6301}, '{1, A_COLOR, 32'h3, 32'h3},
        '{1, 8'h20, 32'h55, 32'h0}, '{1, A_TMO, 32'h00, 32'h00}};

    mpp_top #(.TICK_CYC(10)) DUT (.mclk(mclk), .rstn(rstn),
        .key_pin(key_pin), .pulse_pin(pulse_pin), .proc_value(proc_value),
        .cmp_on(cmp_on), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .disp_value(disp_value), .disp_valid(disp_valid),
        .readout_zero(readout_zero), .color_red(color_red),
        .color_green(color_green), .level_ind(level_ind),
        .param_sel(param_sel), .show_value(show_value), .blink(blink),
        .edit_value(edit_value));
    mpp_panel_model PANEL (.mclk(mclk), .rstn(rstn), .key_req(key_req),
        .pulse_gap(pulse_gap), .key_pin(key_pin), .pulse_pin(pulse_pin));

    ////////////////////////////////////////////////////////////////////////
    // Clock and timeout.
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            num_errors++;
            final_report();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port and key tasks.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic hold(input int k, input int cy);
        @(posedge mclk);
        key_req[k] <= 1'b1;
        repeat (cy) @(posedge mclk);
    endtask
    task automatic press(input int k);
        hold(k, 8);
        key_req[k] <= 1'b0;
        repeat (8) @(posedge mclk);
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial
    begin
        rstn = 1'b0;
        key_req = 4'h0;
        pulse_gap = 20;
        proc_value = 16'sh0;
        cmp_on = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        #1 `CHK("disp_valid", 1'b0, disp_valid)
        `CHK("disp_value", 16'sh0, disp_value)
        @(posedge mclk);
        #1 `CHK("no delay", 1'b1, disp_valid)
        foreach (rows[i])
        begin
            if (rows[i].w)
                wr(rows[i].a, rows[i].d);
            rd(rows[i].a, rv);
            `CHK("register", rows[i].e, rv)
        end
        $display("register test done");
        // Colour follows mode and comparative output.
        for (int m = 0; m < 4; m++)
            for (int c = 0; c < 2; c++)
            begin
                wr(8'h0c, 32'(m));
                cmp_on <= c[0];
                repeat (3) @(posedge mclk);
                exp_red = (m == 1) | (m == 2 & c == 1) | (m == 3 & c == 0);
                `CHK("color_red", exp_red, color_red)
                `CHK("color_green", !exp_red, color_green)
            end
        $display("colour test done");
        // Clamp on and off at threshold boundaries.
        wr(A_TMO, 32'hc7);
        wr(A_CLAMP, 32'h0a01);
        for (int v = -2; v < 12; v += 4)
        begin
            proc_value <= 16'(v);
            repeat (3) @(posedge mclk);
            `CHK("clamped", (v < 10) ? 16'sh0 : 16'(v), disp_value)
        end
        proc_value <= 16'sh0009;
        wr(A_CLAMP, 32'h0a00);
        repeat (3) @(posedge mclk);
        `CHK("unclamped", 16'(9), disp_value)
        $display("clamp test done");
        // Auto-zero after the pulses stop, and recovery.
        wr(A_TMO, 32'h1e);
        pulse_gap <= 0;
        repeat (200) @(posedge mclk);
        `CHK("az early", 1'b0, readout_zero)
        repeat (200) @(posedge mclk);
        `CHK("az late", 1'b1, readout_zero)
        `CHK("az value", 16'sh0, disp_value)
        pulse_gap <= 20;
        repeat (40) @(posedge mclk);
        `CHK("az resume", 1'b0, readout_zero)
        `CHK("resume value", 16'(9), disp_value)
        $display("auto-zero test done");
        // Level entry, edit, admit code, commit and step back.
        hold(K_LVL, 250);
        `CHK("early level", IND_OP, level_ind)
        repeat (80) @(posedge mclk);
        `CHK("init level", IND_INIT, level_ind)
        key_req[K_LVL] <= 1'b0;
        repeat (8) @(posedge mclk);
        `CHK("first param", P_MOVE, param_sel)
        press(K_SHIFT);
        `CHK("show", 1'b1, show_value)
        `CHK("no blink", 1'b0, blink)
        press(K_SHIFT);
        `CHK("blink", 1'b1, blink)
        n = 0;
        while (edit_value !== -16'sd169 && n < 2100)
        begin
            press(K_SHIFT);
            n++;
        end
        `CHK("edit", -16'sd169, edit_value)
        press(K_MODE);
        `CHK("adv level", IND_ADV, level_ind)
        `CHK("adv param", P_TMO, param_sel)
        press(K_SHIFT);
        press(K_SHIFT);
        press(K_UP);
        press(K_MODE);
        `CHK("next param", P_STUP, param_sel)
        `CHK("view name", 1'b0, show_value)
        rd(A_TMO, rv);
        `CHK("committed", 32'h1f, rv)
        hold(K_LVL, 130);
        `CHK("back init", IND_INIT, level_ind)
        key_req[K_LVL] <= 1'b0;
        repeat (8) @(posedge mclk);
        hold(K_LVL, 130);
        `CHK("back op", IND_OP, level_ind)
        key_req[K_LVL] <= 1'b0;
        $display("key test done");
        rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        `CHK("reset valid", 1'b0, disp_valid)
        rstn <= 1'b1;
        rd(A_TMO, rv);
        `CHK("reset tmo", 32'h32, rv)
        $display("reset test done");
        final_report();
    end
endmodule
